/* src/exec_core.sv */
// Execute stage: working register, flags, data memory, return stack
`timescale 1ns/1ps
module exec_core #(
  parameter int MEM_DEPTH = 256,
  parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire exec_pkg::instr_t instr,
  output logic instr_ready,
  output logic [7:0] working_register,
  output exec_pkg::flags_t flags,
  output logic [11:0] pc,
  output logic [11:0] stack_top,
  output logic [3:0] stack_count,
  output logic watchdog_restart,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] mem_q [MEM_DEPTH];
  logic [11:0] stack_q [STACK_DEPTH];
  logic [7:0] acc_q, acc_d;
  exec_pkg::flags_t flags_q, flags_d;
  logic [11:0] pc_q, pc_d;
  logic [3:0] sp_q, sp_d;
  logic busy_q, busy_d;
  logic ready_q, ready_d;
  logic [11:0] top_q, top_d;
  logic wdr_q, wdr_d;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  logic push;
  logic [7:0] mem_rd;
  logic [7:0] result;
  logic zero;
  logic [2:0] slot;

  assign mem_rd = mem_q[instr.addr];
  assign slot = sp_q[2:0];

  // Address of the instruction that follows the one at p
  function automatic logic [11:0] step_pc(input logic [11:0] p);
    return p + exec_pkg::PC_STEP;
  endfunction

  logic_unit u_logic_unit (
    .op(instr.op),
    .working_register(acc_q),
    .mem_data(mem_rd),
    .imm(instr.imm),
    .bit_sel(instr.bit_sel),
    .result(result),
    .zero(zero)
  );

  // ****************************************************************
  // Next-state decode
  // ****************************************************************
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    pc_d = pc_q;
    sp_d = sp_q;
    busy_d = 1'b0;
    wdr_d = 1'b0;
    wr_d = 1'b0;
    wa_d = instr.addr;
    wd_d = result;
    push = 1'b0;
    ready_d = 1'b1;
    // Stack top mirrors the newest entry so no array read reaches a pin
    top_d = (sp_q == 4'h0) ? top_q : stack_q[slot - 3'h1];
    if (busy_q) begin
      // Second cycle of a call: redirect only, nothing else moves
      pc_d = instr.target;
    end else if (instr_valid) begin
      pc_d = step_pc(pc_q);
      unique case (instr.op)
        exec_pkg::OP_AND_MEM, exec_pkg::OP_AND_IMM: begin
          acc_d = result;
          flags_d.zero = zero;
        end
        exec_pkg::OP_AND_TO_MEM: begin
          wr_d = 1'b1;
        end
        exec_pkg::OP_CALL: begin
          push = 1'b1;
          // Stack wraps when full, like the small hardware stack it models
          sp_d = sp_q + 4'h1;
          pc_d = pc_q;
          busy_d = 1'b1;
          ready_d = 1'b0;
          top_d = step_pc(pc_q);
        end
        exec_pkg::OP_CLEAR_MEM, exec_pkg::OP_CLEAR_BIT: begin
          wr_d = 1'b1;
        end
        exec_pkg::OP_CLEAR_WATCHDOG: begin
          wdr_d = 1'b1;
          flags_d.timeout_flag = 1'b0;
          flags_d.powerdown_flag = 1'b0;
        end
        exec_pkg::OP_COMPLEMENT_IN_PLACE: begin
          wr_d = 1'b1;
          flags_d.zero = zero;
        end
        exec_pkg::OP_COMPLEMENT_TO_WORKING: begin
          acc_d = result;
          flags_d.zero = zero;
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Registers: program flow
  // ****************************************************************
  // The call holds ready low for its second cycle, so the target is
  // taken from a request that is still standing, never from a new one.
  // Ready is a register of its own so that the pin has no gate behind it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= exec_pkg::PC_RESET;
      sp_q <= 4'h0;
      busy_q <= 1'b0;
      ready_q <= 1'b1;
      top_q <= exec_pkg::PC_RESET;
    end else if (clk_en) begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      busy_q <= busy_d;
      ready_q <= ready_d;
      top_q <= top_d;
    end
  end

  // ****************************************************************
  // Registers: working value and flags
  // ****************************************************************
  // Flags other than zero are only ever cleared here; nothing in this
  // core ever sets them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 8'h00;
      flags_q <= '0;
    end else if (clk_en) begin
      acc_q <= acc_d;
      flags_q <= flags_d;
    end
  end

  // ****************************************************************
  // Registers: memory write port and watchdog strobe
  // ****************************************************************
  // Strobes last one enabled cycle; a low clock enable stretches them,
  // which a listener on the free-running clock must allow for.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdr_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
    end else if (clk_en) begin
      wdr_q <= wdr_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
    end
  end

  // ****************************************************************
  // Storage arrays
  // ****************************************************************
  // Memory and stack carry no reset; software initialises them.
  // Writes are gated by the enable so a frozen core leaves them intact.
  always_ff @(posedge clk) begin
    if (clk_en && !sys_rst && wr_d) begin
      mem_q[wa_d] <= wd_d;
    end
    if (clk_en && !sys_rst && push) begin
      stack_q[slot] <= step_pc(pc_q);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every pin is a register; the memory port address and data follow every enabled cycle, write or not.
  assign instr_ready = ready_q;
  assign working_register = acc_q;
  assign flags = flags_q;
  assign pc = pc_q;
  assign stack_top = top_q;
  assign stack_count = sp_q;
  assign watchdog_restart = wdr_q;
  assign mem_wr_en = wr_q;
  assign mem_wr_addr = wa_q;
  assign mem_wr_data = wd_q;
endmodule

/* src/exec_pkg.sv */
// Package of operation codes, carriers and constants for the execute block
// Function
// - AND working register with memory byte into working register; zero only.
// - AND working register with immediate into working register; zero only.
// - AND working register with memory byte, result written back to memory.
// - Call pushes program counter plus one onto the return stack.
// - Call loads target address, takes two cycles, leaves flags unchanged.
// - Clear-memory writes 00H to the byte; no flag changes.
// - Clear-bit zeroes only the chosen bit; other bits and flags kept.
// - Complement-to-working puts inverted memory byte into working register.
// - Watchdog clear restarts watchdog, zeroes timeout and powerdown flags.
// - In-place complement inverts the memory byte and updates zero flag.
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam int CALL_CYCLES = 2;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_AND_MEM,
    OP_AND_IMM,
    OP_AND_TO_MEM,
    OP_CALL,
    OP_CLEAR_MEM,
    OP_CLEAR_BIT,
    OP_CLEAR_WATCHDOG,
    OP_COMPLEMENT_IN_PLACE,
    OP_COMPLEMENT_TO_WORKING
  } opcode_t;

  typedef struct packed {
    opcode_t op;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [11:0] target;
  } instr_t;

  typedef struct packed {
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
  } flags_t;
endpackage

/* src/logic_unit.sv */
// Combinational logic unit for the execute block
`timescale 1ns/1ps
module logic_unit (
  input wire exec_pkg::opcode_t op,
  input wire logic [7:0] working_register,
  input wire logic [7:0] mem_data,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  output logic [7:0] result,
  output logic zero
);
  always_comb begin
    unique case (op)
      exec_pkg::OP_AND_MEM: result = working_register & mem_data;
      exec_pkg::OP_AND_IMM: result = working_register & imm;
      exec_pkg::OP_AND_TO_MEM: result = working_register & mem_data;
      exec_pkg::OP_CLEAR_MEM: result = exec_pkg::ZERO_BYTE;
      exec_pkg::OP_CLEAR_BIT: begin
        result = mem_data & ~(8'h01 << bit_sel);
      end
      exec_pkg::OP_COMPLEMENT_IN_PLACE: result = ~mem_data;
      exec_pkg::OP_COMPLEMENT_TO_WORKING: result = ~mem_data;
      default: result = exec_pkg::ZERO_BYTE;
    endcase
    zero = (result == exec_pkg::ZERO_BYTE);
  end
endmodule

/* verification/exec_core_properties.sv */
// Port-level assertions for the execute block
`timescale 1ns/1ps
module exec_core_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire exec_pkg::instr_t instr,
  input wire logic instr_ready,
  input wire logic [7:0] working_register,
  input wire exec_pkg::flags_t flags,
  input wire logic [11:0] pc,
  input wire logic [11:0] stack_top,
  input wire logic watchdog_restart,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic go = clk_en && instr_valid && instr_ready;
  wire logic [3:0] op = instr.op;
  chk_and_imm: assert property (
    go && op == exec_pkg::OP_AND_IMM |=>
    working_register == ($past(working_register) & $past(instr.imm)))
    else $error("and immediate wrong");
  chk_zero_flag: assert property (
    go && op == exec_pkg::OP_AND_MEM |=>
    flags.zero == (working_register == 8'h00)) else $error("zero flag wrong");
  chk_call_push: assert property (
    go && op == exec_pkg::OP_CALL |=>
    stack_top == $past(pc) + 12'h001 && !instr_ready) else $error("bad push");
  chk_call_target: assert property (
    go && op == exec_pkg::OP_CALL |=>
    ##1 pc == $past(instr.target, 2) && flags == $past(flags, 2))
    else $error("call target wrong");
  chk_clear_mem: assert property (
    go && op == exec_pkg::OP_CLEAR_MEM |=>
    mem_wr_en && mem_wr_data == 8'h00 && $stable(flags)) else $error("clr");
  chk_clear_bit: assert property (
    go && op == exec_pkg::OP_CLEAR_BIT |=>
    mem_wr_en && !mem_wr_data[$past(instr.bit_sel)] && $stable(flags))
    else $error("clear bit wrong");
  chk_wdt_clear: assert property (
    go && op == exec_pkg::OP_CLEAR_WATCHDOG |=>
    watchdog_restart && flags == {$past(flags.zero), 2'b00})
    else $error("watchdog clear wrong");
  chk_and_mem: assert property (
    go && op == exec_pkg::OP_AND_TO_MEM |=>
    mem_wr_en && (mem_wr_data & ~$past(working_register)) == 8'h00)
    else $error("and to memory wrong");
  chk_cpl_zero: assert property (
    go && op == exec_pkg::OP_COMPLEMENT_IN_PLACE |=>
    mem_wr_en && flags.zero == (mem_wr_data == 8'h00)) else $error("cpl");
  chk_cpl_working: assert property (
    go && op == exec_pkg::OP_COMPLEMENT_TO_WORKING |=>
    !mem_wr_en && flags.zero == (working_register == 8'h00))
    else $error("complement to working wrong");
  cov_call: cover property (go && op == exec_pkg::OP_CALL);
  cov_clear_bit: cover property (go && op == exec_pkg::OP_CLEAR_BIT);
  cov_restart: cover property (watchdog_restart);
endmodule
bind exec_core exec_core_properties i_chk (.clk, .sys_rst, .clk_en,
  .instr_valid, .instr, .instr_ready, .working_register, .flags, .pc,
  .stack_top, .watchdog_restart, .mem_wr_en, .mem_wr_data);

/* verification/mcu_and_clear_call_exec_tb.sv */
// Self-checking bench for the execute block
`timescale 1ns/1ps
module mcu_and_clear_call_exec_tb;
  typedef logic [33:0] row_t;
  logic clk = 0, sys_rst = 1, clk_en = 1, instr_valid = 0;
  exec_pkg::instr_t instr = '0;
  logic instr_ready, watchdog_restart, mem_wr_en;
  logic [7:0] working_register, mem_wr_addr, mem_wr_data;
  exec_pkg::flags_t flags;
  logic [11:0] pc, stack_top, pc_exp;
  logic [3:0] stack_count;
  row_t rows [10];
  int bad_count = 0, n_checks = 0;
  always #20 clk = ~clk;
  exec_core i_dut (.clk, .sys_rst, .clk_en, .instr_valid, .instr,
    .instr_ready, .working_register, .flags, .pc, .stack_top, .stack_count,
    .watchdog_restart, .mem_wr_en, .mem_wr_addr, .mem_wr_data);
  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Holds the request for n edges so a call keeps its target in cycle two
  task automatic step(exec_pkg::instr_t i, int n);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= i;
    repeat (n) @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    row_t r;
    exec_pkg::instr_t i;
    // Row: op, imm, bit, working value, zero, {write, restart}, write data
    rows[0] = {4'h5, 8'h00, 3'h0, 8'h00, 1'b0, 2'h2, 8'h00};
    rows[1] = {4'h9, 8'h00, 3'h0, 8'hFF, 1'b0, 2'h0, 8'h00};
    rows[2] = {4'h2, 8'h3C, 3'h0, 8'h3C, 1'b0, 2'h0, 8'h00};
    rows[3] = {4'h8, 8'h00, 3'h0, 8'h3C, 1'b0, 2'h2, 8'hFF};
    rows[4] = {4'h6, 8'h00, 3'h2, 8'h3C, 1'b0, 2'h2, 8'hFB};
    rows[5] = {4'h3, 8'h00, 3'h0, 8'h3C, 1'b0, 2'h2, 8'h38};
    rows[6] = {4'h1, 8'h00, 3'h0, 8'h38, 1'b0, 2'h0, 8'h00};
    rows[7] = {4'h2, 8'h00, 3'h0, 8'h00, 1'b1, 2'h0, 8'h00};
    rows[8] = {4'h7, 8'h00, 3'h0, 8'h00, 1'b1, 2'h1, 8'h00};
    rows[9] = {4'h5, 8'h00, 3'h0, 8'h00, 1'b1, 2'h2, 8'h00};
    pc_exp = 12'h000;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[k]) begin
      r = rows[k];
      i = '0;
      i.op = exec_pkg::opcode_t'(r[33:30]);
      i.addr = 8'h10;
      i.imm = r[29:22];
      i.bit_sel = r[21:19];
      step(i, 1);
      pc_exp++;
      check("working", 32'(working_register),
        32'(r[18:11]));
      check("zero", 32'(flags.zero), 32'(r[10]));
      check("wr_restart", 32'({mem_wr_en, watchdog_restart}),
        32'(r[9:8]));
      if (r[9]) begin
        check("wr_data", 32'(mem_wr_data),
          32'(r[7:0]));
        check("wr_addr", 32'(mem_wr_addr), 32'h10);
      end
    end
    i = '0;
    i.op = exec_pkg::OP_CALL;
    i.target = 12'hA5C;
    step(i, 2);
    check("pc", 32'(pc), 32'h0A5C);
    check("push", 32'({stack_count, stack_top}),
      32'({4'h1, pc_exp + 12'h001}));
    check("flags", 32'(flags), 32'h4);
    check("ready", 32'(instr_ready), 32'h1);
    // Low enable: a request that would load FFH must leave all as it was
    i = '0;
    i.op = exec_pkg::OP_COMPLEMENT_TO_WORKING;
    i.addr = 8'h10;
    @(posedge clk);
    clk_en <= 1'b0;
    step(i, 1);
    check("frozen", 32'(working_register), 32'h0);
    check("frozen_pc", 32'(pc), 32'h0A5C);
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check("reset", 32'({flags, working_register, stack_count, pc}),
      32'h0);
    check("reset_ready", 32'(instr_ready), 32'h1);
    finish_test();
  end
endmodule
